// *** rtl/fiap_consts.vh ***
// Constants for the flash in-application erase/write controller
`ifndef FIAP_CONSTS_VH
`define FIAP_CONSTS_VH

// Operation mode codes
`define FIAP_MODE_WRITE   3'h0
`define FIAP_MODE_ERASE   3'h1
`define FIAP_MODE_READ    3'h3
`define FIAP_MODE_UNLOCK  3'h6

// Unlock key bytes, word1..word3 low then high
`define FIAP_KEY1_LOW     8'h00
`define FIAP_KEY2_LOW     8'h0D
`define FIAP_KEY3_LOW     8'hC3
`define FIAP_KEY1_HIGH    8'h04
`define FIAP_KEY2_HIGH    8'h09
`define FIAP_KEY3_HIGH    8'h40

// Geometry
`define FIAP_ADDR_W       14
`define FIAP_WORD_IDX_W   5
`define FIAP_PAGE_LAST    5'h1F
`define FIAP_WORD_W       16
`define FIAP_ERASED_WORD  16'h0000

// Timing
`define FIAP_CLK_HZ       10000000
`define FIAP_UNLOCK_CYC   12'h400
`define FIAP_OP_CYC       8'h40

`endif

// *** rtl/fiap_ctrl.v ***
// Flash in-application erase/write controller top
//
// How it works
// - Correct unlock sets the permit bit; erase/write starts only with it set.
// - In erase mode each high-byte write tags the word and bumps address.
// - Tag address stops at word 31 of the page.
// - Erase clears only tagged words; software must tag them first.
// - Erased words read back as zero.
// - Buffer-clear empties the buffer so a failed page can be rewritten.
// - Software clearing the permit bit revokes permission at once.
// - Unlock mode and trigger accepted in one write; trigger starts timer.
// - Timer expiry clears the trigger bit, whatever was written.
// - Permission granted only if all six key bytes match.
// - Buffer holds 32 words of the page chosen by address bits 13..5.
// - Buffer address increments after each word load.
// - Buffer address stops at the last page word, never wraps.
// - Erase mode 001 with initiate erases the tagged page, then clears bit.
// - Initiate in write mode programs buffered words; bit drops when done.
// - The core is stalled while an erase or write runs.
// - High-byte write loads the 16-bit word and bumps the address pair.
// - Writing one to the permit bit has no effect.
// - Hardware clears buffer-clear once clearing is done.
`timescale 1ns/1ps
`include "fiap_consts.vh"

module fiap_ctrl #(
	parameter UNLOCK_CYC = `FIAP_UNLOCK_CYC,
	parameter OP_CYC     = `FIAP_OP_CYC,
	parameter ADDR_W     = `FIAP_ADDR_W
) (
	// Clock and reset
	input  wire              sys_clk,
	input  wire              rst_b,
	// Main control register write
	input  wire              ctl_wr,
	input  wire [2:0]        ctl_mode,
	input  wire              ctl_trigger,
	input  wire              ctl_initiate,
	input  wire              ctl_permit,
	// Buffer clear request
	input  wire              clr_wr,
	// Address pair writes
	input  wire              addr_low_wr,
	input  wire              addr_high_wr,
	input  wire [7:0]        addr_wdata,
	// Data byte writes
	input  wire              word0_low_wr,
	input  wire              word0_high_wr,
	input  wire              key1_low_wr,
	input  wire              key1_high_wr,
	input  wire              key2_low_wr,
	input  wire              key2_high_wr,
	input  wire              key3_low_wr,
	input  wire              key3_high_wr,
	input  wire [7:0]        data_wdata,
	// Flash array read port
	input  wire [ADDR_W-1:0] rd_addr,
	output reg  [15:0]       rd_data,
	// Status
	output reg               erase_write_permitted,
	output reg  [2:0]        flash_op_mode,
	output reg               unlock_trigger,
	output reg               write_initiate,
	output reg               buffer_clear,
	output reg  [ADDR_W-1:0] flash_addr,
	output reg               cpu_stall
);

	// ----------------------------------------------------------------
	// Local state
	// ----------------------------------------------------------------
	localparam ST_IDLE  = 2'h0;
	localparam ST_ERASE = 2'h1;
	localparam ST_WRITE = 2'h2;
	localparam ST_CLEAR = 2'h3;
	localparam PAGE_W   = ADDR_W - `FIAP_WORD_IDX_W;
	localparam WORDS    = 1 << `FIAP_WORD_IDX_W;

	reg [1:0]   state;
	reg [11:0]  unlock_cnt;
	reg [7:0]   op_cnt;
	reg [7:0]   word0_low;
	reg [5:0]   key_ok;
	reg [`FIAP_WORD_IDX_W-1:0] scan_idx;
	reg [15:0]  flash_mem [0:(1<<ADDR_W)-1];

	wire [`FIAP_WORD_IDX_W-1:0] word_idx = flash_addr[`FIAP_WORD_IDX_W-1:0];
	wire [PAGE_W-1:0]           page_sel = flash_addr[ADDR_W-1:`FIAP_WORD_IDX_W];
	wire [15:0] buf_word;
	wire        buf_tag;
	wire        at_last  = (word_idx == `FIAP_PAGE_LAST);
	wire        idle     = (state == ST_IDLE);
	wire        key_live = unlock_trigger && (flash_op_mode == `FIAP_MODE_UNLOCK);
	wire        erase_md = (flash_op_mode == `FIAP_MODE_ERASE);
	wire        buf_load = word0_high_wr && idle && erase_write_permitted &&
			(erase_md || flash_op_mode == `FIAP_MODE_WRITE);
	wire        buf_clr  = (state == ST_CLEAR);

	// ----------------------------------------------------------------
	// Page buffer
	// ----------------------------------------------------------------
	fiap_page_buffer #(
		.WORDS    (WORDS),
		.IDX_W    (`FIAP_WORD_IDX_W),
		.DW       (`FIAP_WORD_W)
	) u_buf (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.clear    (buf_clr),
		.load     (buf_load),
		.tag_only (erase_md),
		.idx      (word_idx),
		.wdata    ({data_wdata, word0_low}),
		.rd_idx   (scan_idx),
		.rd_data  (buf_word),
		.rd_tag   (buf_tag)
	);

	// ----------------------------------------------------------------
	// Control register, unlock and key check
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			erase_write_permitted <= 1'b0;
			flash_op_mode         <= `FIAP_MODE_WRITE;
			unlock_trigger        <= 1'b0;
			unlock_cnt            <= 12'h000;
			key_ok                <= 6'h00;
		end else begin
			if (ctl_wr && idle) begin
				flash_op_mode <= ctl_mode;
				if (!ctl_permit)
					erase_write_permitted <= 1'b0;
				if (ctl_trigger && ctl_mode == `FIAP_MODE_UNLOCK) begin
					unlock_trigger <= 1'b1;
					unlock_cnt     <= UNLOCK_CYC[11:0];
					key_ok         <= 6'h00;
				end
			end
			if (unlock_trigger) begin
				if (unlock_cnt == 12'h001) begin
					unlock_trigger <= 1'b0;
					if (key_ok == 6'h3F)
						erase_write_permitted <= 1'b1;
				end
				unlock_cnt <= unlock_cnt - 12'h001;
			end
			// Keys only count while the window is open
			if (key_live) begin
				if (key1_low_wr)
					key_ok[0] <= (data_wdata == `FIAP_KEY1_LOW);
				if (key2_low_wr)
					key_ok[1] <= (data_wdata == `FIAP_KEY2_LOW) && key_ok[0];
				if (key3_low_wr)
					key_ok[2] <= (data_wdata == `FIAP_KEY3_LOW) && key_ok[1];
				if (key1_high_wr)
					key_ok[3] <= (data_wdata == `FIAP_KEY1_HIGH);
				if (key2_high_wr)
					key_ok[4] <= (data_wdata == `FIAP_KEY2_HIGH) && key_ok[3];
				if (key3_high_wr)
					key_ok[5] <= (data_wdata == `FIAP_KEY3_HIGH) && key_ok[4];
			end
		end
	end

	// ----------------------------------------------------------------
	// Address pair and low data byte
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			flash_addr <= {ADDR_W{1'b0}};
			word0_low  <= 8'h00;
		end else begin
			if (word0_low_wr)
				word0_low <= data_wdata;
			if (addr_low_wr && idle)
				flash_addr[7:0] <= addr_wdata;
			else if (addr_high_wr && idle)
				flash_addr[ADDR_W-1:8] <= addr_wdata[ADDR_W-9:0];
			else if (buf_load && !at_last)
				flash_addr <= flash_addr + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer: erase, program, buffer clear
	// ----------------------------------------------------------------
	// One page word is handled per cycle; the rest of op time models array busy.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			state          <= ST_IDLE;
			write_initiate <= 1'b0;
			buffer_clear   <= 1'b0;
			cpu_stall      <= 1'b0;
			op_cnt         <= 8'h00;
			scan_idx       <= {`FIAP_WORD_IDX_W{1'b0}};
		end else begin
			case (state)
			ST_IDLE: begin
				scan_idx <= {`FIAP_WORD_IDX_W{1'b0}};
				op_cnt   <= OP_CYC[7:0];
				if (clr_wr) begin
					buffer_clear <= 1'b1;
					state        <= ST_CLEAR;
				end else if (ctl_wr && ctl_initiate && erase_write_permitted) begin
					write_initiate <= 1'b1;
					cpu_stall      <= 1'b1;
					if (ctl_mode == `FIAP_MODE_ERASE)
						state <= ST_ERASE;
					else if (ctl_mode == `FIAP_MODE_WRITE)
						state <= ST_WRITE;
					else begin
						write_initiate <= 1'b0;
						cpu_stall      <= 1'b0;
					end
				end
			end
			ST_ERASE, ST_WRITE: begin
				if (scan_idx != `FIAP_PAGE_LAST)
					scan_idx <= scan_idx + 1'b1;
				if (op_cnt == 8'h01 && scan_idx == `FIAP_PAGE_LAST) begin
					write_initiate <= 1'b0;
					cpu_stall      <= 1'b0;
					state          <= ST_IDLE;
				end
				if (op_cnt != 8'h01)
					op_cnt <= op_cnt - 8'h01;
			end
			ST_CLEAR: begin
				buffer_clear <= 1'b0;
				state        <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flash array model: write per tagged word, read port
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (state == ST_ERASE && buf_tag)
			flash_mem[{page_sel, scan_idx}] <= `FIAP_ERASED_WORD;
		else if (state == ST_WRITE && buf_tag)
			flash_mem[{page_sel, scan_idx}] <= buf_word;
	end

	always @(posedge sys_clk) begin
		if (!rst_b)
			rd_data <= 16'h0000;
		else
			rd_data <= flash_mem[rd_addr];
	end

endmodule // fiap_ctrl

// *** rtl/fiap_page_buffer.v ***
// Page write buffer with per-word tag flags
`timescale 1ns/1ps
`include "fiap_consts.vh"

module fiap_page_buffer #(
	parameter WORDS = 32,
	parameter IDX_W = 5,
	parameter DW    = 16
) (
	// Clock and reset
	input  wire              sys_clk,
	input  wire              rst_b,
	// Control
	input  wire              clear,
	input  wire              load,
	input  wire              tag_only,
	input  wire [IDX_W-1:0]  idx,
	input  wire [DW-1:0]     wdata,
	// Readout
	input  wire [IDX_W-1:0]  rd_idx,
	output wire [DW-1:0]     rd_data,
	output wire              rd_tag
);

	// Each entry owns its flops; the flat buses only gather them for readout
	wire [DW*WORDS-1:0] mem_flat;
	wire [WORDS-1:0]    tag;

	genvar g;
	generate
		for (g = 0; g < WORDS; g = g + 1) begin : g_word
			reg [DW-1:0] word_q;
			reg          tag_q;
			always @(posedge sys_clk) begin
				if (!rst_b || clear) begin
					word_q <= `FIAP_ERASED_WORD;
					tag_q  <= 1'b0;
				end else if (load && idx == g) begin
					if (!tag_only)
						word_q <= wdata;
					tag_q <= 1'b1;
				end
			end
			assign mem_flat[g*DW +: DW] = word_q;
			assign tag[g]               = tag_q;
		end
	endgenerate

	assign rd_data = mem_flat[rd_idx*DW +: DW];
	assign rd_tag  = tag[rd_idx];

endmodule // fiap_page_buffer

// *** verif/fiap_ctrl_monitor.sv ***
// Assertion checker for the flash in-application erase/write controller
`timescale 1ns/1ps

module fiap_ctrl_monitor #(
	parameter int UNLOCK_CYC = 16,
	parameter int OP_CYC     = 33,
	parameter int ADDR_W     = 14
) (
	// Clock and reset
	input wire logic              sys_clk,
	input wire logic              rst_b,
	// Requests
	input wire logic              ctl_wr,
	input wire logic [2:0]        ctl_mode,
	input wire logic              ctl_trigger,
	input wire logic              ctl_initiate,
	input wire logic              ctl_permit,
	input wire logic              clr_wr,
	input wire logic              addr_low_wr,
	input wire logic              addr_high_wr,
	input wire logic              word0_high_wr,
	// Status
	input wire logic              erase_write_permitted,
	input wire logic              unlock_trigger,
	input wire logic              write_initiate,
	input wire logic              buffer_clear,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic              cpu_stall
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// Cycles the unlock window has been open so far
	logic [15:0] win_cnt;
	always @(posedge sys_clk) begin
		if (!rst_b || !unlock_trigger)
			win_cnt <= 16'h0000;
		else
			win_cnt <= win_cnt + 16'h0001;
	end

	sequence s_busy;
		write_initiate && cpu_stall;
	endsequence
	sequence s_idle;
		!write_initiate && !cpu_stall;
	endsequence

	chk_no_sw_set: assert property (ctl_wr && ctl_permit && !erase_write_permitted
		&& !unlock_trigger |=> !erase_write_permitted) else $error("permit set by software");
	chk_sw_revoke: assert property (ctl_wr && !ctl_permit && !cpu_stall && !unlock_trigger
		|=> !erase_write_permitted) else $error("permit not revoked");
	chk_trig_start: assert property (ctl_wr && ctl_trigger && ctl_mode == 3'h6 && !cpu_stall
		&& !unlock_trigger |=> unlock_trigger) else $error("unlock window not opened");
	chk_window_len: assert property ($fell(unlock_trigger) |-> win_cnt == UNLOCK_CYC)
		else $error("unlock window length wrong");
	chk_grant_expiry: assert property ($rose(erase_write_permitted) |-> $fell(unlock_trigger))
		else $error("permit granted outside expiry");
	chk_op_refused: assert property (ctl_wr && ctl_initiate && !erase_write_permitted
		&& !cpu_stall && !unlock_trigger |=> !write_initiate) else $error("op without permit");
	chk_op_start: assert property (ctl_wr && ctl_initiate && ctl_permit && erase_write_permitted
		&& !cpu_stall && !clr_wr && !unlock_trigger && ctl_mode[2:1] == 2'b00
		|=> s_busy[*8] ##[1:200] s_idle) else $error("operation timing wrong");
	chk_clear_pulse: assert property (clr_wr && !cpu_stall |=> buffer_clear ##1 !buffer_clear)
		else $error("buffer clear not a single pulse");
	chk_addr_incr: assert property (word0_high_wr && !cpu_stall && !addr_low_wr && !addr_high_wr
		&& flash_addr[4:0] != 5'h1F |=> flash_addr == $past(flash_addr) + 1'b1)
		else $error("address not advanced");
	chk_addr_sat: assert property (word0_high_wr && !cpu_stall && !addr_low_wr && !addr_high_wr
		&& flash_addr[4:0] == 5'h1F |=> $stable(flash_addr)) else $error("address ran past page end");
endmodule // fiap_ctrl_monitor

bind fiap_ctrl fiap_ctrl_monitor #(.UNLOCK_CYC(UNLOCK_CYC), .OP_CYC(OP_CYC), .ADDR_W(ADDR_W)) u_mon (
	.sys_clk(sys_clk), .rst_b(rst_b), .ctl_wr(ctl_wr), .ctl_mode(ctl_mode),
	.ctl_trigger(ctl_trigger), .ctl_initiate(ctl_initiate), .ctl_permit(ctl_permit),
	.clr_wr(clr_wr), .addr_low_wr(addr_low_wr), .addr_high_wr(addr_high_wr),
	.word0_high_wr(word0_high_wr), .erase_write_permitted(erase_write_permitted),
	.unlock_trigger(unlock_trigger), .write_initiate(write_initiate),
	.buffer_clear(buffer_clear), .flash_addr(flash_addr), .cpu_stall(cpu_stall));

// *** verif/tb_flash_iap_erase_write_control.sv ***
// Self-checking bench for the flash in-application erase/write controller
`timescale 1ns/1ps
`include "fiap_consts.vh"

module tb_flash_iap_erase_write_control;
	localparam int          UNL  = 16;
	localparam logic [47:0] KEYS = {`FIAP_KEY3_HIGH, `FIAP_KEY3_LOW, `FIAP_KEY2_HIGH,
		`FIAP_KEY2_LOW, `FIAP_KEY1_HIGH, `FIAP_KEY1_LOW};
	logic        sys_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic [2:0]  ctl_mode = 3'h0;
	logic [2:0]  ctl_bits = 3'h0;
	logic [11:0] stb     = 12'h000;
	logic [7:0]  wdat    = 8'h00;
	logic [13:0] rd_addr = 14'h0000;
	logic [13:0] base;
	logic [15:0] w [32];
	wire  [15:0] rd_data;
	wire  [2:0]  flash_op_mode;
	wire  [13:0] flash_addr;
	wire         erase_write_permitted, unlock_trigger, write_initiate, buffer_clear, cpu_stall;
	int          miscompares = 0;
	int          cmp_count   = 0;
	int          k;
	integer      seed = 32'hCDF9;

	fiap_ctrl #(.UNLOCK_CYC(UNL), .OP_CYC(33), .ADDR_W(14)) dut (
		.sys_clk(sys_clk), .rst_b(rst_b), .ctl_wr(stb[0]), .ctl_mode(ctl_mode),
		.ctl_trigger(ctl_bits[2]), .ctl_initiate(ctl_bits[1]), .ctl_permit(ctl_bits[0]),
		.clr_wr(stb[1]), .addr_low_wr(stb[2]), .addr_high_wr(stb[3]), .addr_wdata(wdat),
		.word0_low_wr(stb[4]), .word0_high_wr(stb[5]), .key1_low_wr(stb[6]),
		.key1_high_wr(stb[7]), .key2_low_wr(stb[8]), .key2_high_wr(stb[9]),
		.key3_low_wr(stb[10]), .key3_high_wr(stb[11]), .data_wdata(wdat),
		.rd_addr(rd_addr), .rd_data(rd_data), .erase_write_permitted(erase_write_permitted),
		.flash_op_mode(flash_op_mode), .unlock_trigger(unlock_trigger),
		.write_initiate(write_initiate), .buffer_clear(buffer_clear),
		.flash_addr(flash_addr), .cpu_stall(cpu_stall));

	always #50 sys_clk = ~sys_clk;

	// Buffer index stops at the last page word
	function automatic int sat(input int i);
		return (i > 31) ? 31 : i;
	endfunction

	task automatic final_report();
		if (miscompares == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One write strobe for a cycle; an idle edge follows so strobes never merge
	task automatic put(input int n, input logic [7:0] d);
		@(posedge sys_clk);
		stb  <= 12'h001 << n;
		wdat <= d;
		@(posedge sys_clk);
		stb <= 12'h000;
		#1;
	endtask

	task automatic ctl(input logic [2:0] m, input logic [2:0] b);
		@(posedge sys_clk);
		ctl_mode <= m;
		ctl_bits <= b;
		put(0, 8'h00);
	endtask

	task automatic set_addr(input logic [13:0] a);
		put(2, a[7:0]);
		put(3, {2'b00, a[13:8]});
	endtask

	task automatic unlock(input int bad, input int late);
		ctl(`FIAP_MODE_UNLOCK, 3'b101);
		repeat (late) @(posedge sys_clk);
		for (int i = 0; i < 6; i++)
			put(6 + i, KEYS[8*i +: 8] ^ ((i == bad) ? 8'h5A : 8'h00));
		repeat (UNL + 4) @(posedge sys_clk);
		#1;
		chk({15'h0000, unlock_trigger}, 16'h0000);
	endtask

	task automatic wait_done();
		for (k = 0; k < 200 && write_initiate !== 1'b0; k++)
			@(posedge sys_clk);
		#1;
		if (k == 200) begin
			miscompares++;
			final_report();
		end
	endtask

	task automatic rd(input logic [13:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		rd_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(rd_data, e);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		chk({8'h00, erase_write_permitted, unlock_trigger, write_initiate, buffer_clear,
			cpu_stall, flash_op_mode}, 16'h0000);
		ctl(`FIAP_MODE_WRITE, 3'b011);
		chk({14'h0000, erase_write_permitted, write_initiate}, 16'h0000);
		unlock($unsigned($random(seed)) % 6, 0);
		chk({15'h0000, erase_write_permitted}, 16'h0000);
		unlock(6, UNL + 2);
		chk({15'h0000, erase_write_permitted}, 16'h0000);
		unlock(6, 0);
		chk({15'h0000, erase_write_permitted}, 16'h0001);
		// Tag the top three words of a random page, running into the boundary
		base = {9'($random(seed)), 5'h00};
		ctl(`FIAP_MODE_ERASE, 3'b001);
		put(1, 8'h00);
		set_addr(base + 14'd29);
		repeat (4) put(5, 8'($random(seed)));
		chk({2'b00, flash_addr}, {2'b00, base + 14'd31});
		ctl(`FIAP_MODE_ERASE, 3'b011);
		chk({14'h0000, write_initiate, cpu_stall}, 16'h0003);
		wait_done();
		for (int i = 29; i < 32; i++)
			rd(base + 14'(i), `FIAP_ERASED_WORD);
		// Load one word past the page end; the last word is overwritten in place
		ctl(`FIAP_MODE_WRITE, 3'b001);
		put(1, 8'h00);
		set_addr(base);
		for (int i = 0; i < 33; i++) begin
			w[sat(i)] = 16'($random(seed));
			put(4, w[sat(i)][7:0]);
			put(5, w[sat(i)][15:8]);
			chk({2'b00, flash_addr}, {2'b00, base + 14'(sat(i + 1))});
		end
		ctl(`FIAP_MODE_WRITE, 3'b011);
		chk({15'h0000, cpu_stall}, 16'h0001);
		wait_done();
		for (int i = 0; i < 32; i++)
			rd(base + 14'(i), w[i]);
		ctl(`FIAP_MODE_WRITE, 3'b000);
		chk({15'h0000, erase_write_permitted}, 16'h0000);
		ctl(`FIAP_MODE_WRITE, 3'b011);
		chk({15'h0000, write_initiate}, 16'h0000);
		final_report();
	end
endmodule // tb_flash_iap_erase_write_control
